/* File: src/hpsr_pkg.sv */
// constants for the host port strobe/ready handshake block
// assumes a single 20 MHz clock and synchronous active-high reset
`default_nettype none
package hpsr_pkg;
  // clock and derived counts
  localparam int CLK_PERIOD_NS = 50;
  localparam int DATA_LEAD_NS = 2 * CLK_PERIOD_NS - 4; // data valid before ready low
  localparam int SETTLE_CYC = (DATA_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] SETTLE_CNT = 2'(SETTLE_CYC);
  // widths
  localparam int HW_W = 16;
  localparam int WORD_W = 32;
  // access type encodings
  localparam logic [1:0] ACC_CTRL = 2'h0;
  localparam logic [1:0] ACC_DATA_INC = 2'h1;
  localparam logic [1:0] ACC_ADDR = 2'h2;
  localparam logic [1:0] ACC_DATA = 2'h3;
  // reset values
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [15:0] HW_RST = 16'h0000;
  // internal completion kinds
  localparam logic OP_WRITE = 1'b0;
  localparam logic OP_READ_INC = 1'b1;
endpackage
`default_nettype wire

/* File: src/hpsr_port.sv */
// host port handshake: strobe forming, select capture, ready sequencing, data bus
// assumes host pins are synchronous to clk and the memory side answers each request
// Function
// RL1: access strobe is not(strobe a xor strobe b) or chip select
// RL2: ready output forced low whenever chip select is high
// RL3: ready driven high at chip select fall while previous operation completes
// RL4: data read first half issues fetch; ready high until data loaded
// RL5: after second half of data write or autoinc read, ready high during completion
// RL6: other accesses keep ready low throughout
// RL7: control and address register accesses never change ready
// RL8: host keeps access strobe low until ready goes low
// RL9: host pulses address strobe at most once per access strobe
// RL10: host holds access strobe low at least four clock periods
// RL11: host keeps access strobe high at least four clock periods between accesses
// RL12: read data valid at least two periods less 4 ns before ready low
// RL13: selects captured at address strobe fall, else at access strobe fall
`default_nettype none
module hpsr_port
  import hpsr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // host pins
  input wire logic port_chip_select_n,
  input wire logic data_strobe_a,
  input wire logic data_strobe_b,
  input wire logic addr_strobe_n,
  input wire logic [1:0] access_type_select,
  input wire logic read_write_select,
  input wire logic halfword_select,
  input wire logic [15:0] port_data_bus_in,
  output logic [15:0] port_data_bus_out,
  output logic [15:0] port_data_bus_oe,
  output logic port_ready_n,
  // fetch path to the internal dma engine
  output logic fetch_req,
  input wire logic fetch_done,
  input wire logic [31:0] fetch_data,
  // completion of data writes and autoincrement reads
  output logic op_req,
  output logic op_kind,
  output logic [31:0] op_data,
  input wire logic op_done,
  // control and address register side
  output logic reg_wr,
  output logic [1:0] reg_wr_sel,
  output logic reg_wr_half,
  output logic [15:0] reg_wr_data,
  input wire logic [31:0] ctrl_rd_data,
  input wire logic [31:0] addr_rd_data
);

  logic access_strobe_n;
  logic strobe_prev_r;
  logic has_prev_r;
  logic has_seen_r;
  logic [1:0] has_type_r;
  logic has_rw_r;
  logic has_half_r;
  logic [1:0] cur_type_r;
  logic cur_rd_r;
  logic cur_half_r;
  logic strobe_fall;
  logic strobe_rise;
  logic has_fall;
  logic [1:0] sel_type;
  logic sel_rd;
  logic sel_half;
  logic busy_r;
  logic fetch_pend_r;
  logic [1:0] settle_r;
  logic [31:0] data_r;
  logic [15:0] dout_r;
  logic oe_r;
  logic fetch_start;

  function automatic logic is_data(input logic [1:0] t);
    is_data = (t == ACC_DATA_INC) || (t == ACC_DATA);
  endfunction

  function automatic logic [15:0] half_of(input logic [31:0] w, input logic h);
    half_of = h ? w[31:16] : w[15:0];
  endfunction

  // strobe forming and edge detection
  assign access_strobe_n = ~(data_strobe_a ^ data_strobe_b) | port_chip_select_n; // RL1
  assign strobe_fall = strobe_prev_r & ~access_strobe_n;
  assign strobe_rise = ~strobe_prev_r & access_strobe_n;
  assign has_fall = has_prev_r & ~addr_strobe_n;

  always_ff @(posedge clk) begin
    if (srst) begin
      strobe_prev_r <= 1'b1;
      has_prev_r <= 1'b1;
    end else begin
      strobe_prev_r <= access_strobe_n;
      has_prev_r <= addr_strobe_n;
    end
  end

  // address strobe capture; a second pulse in one access is the host's fault
  always_ff @(posedge clk) begin
    if (srst) begin
      has_seen_r <= 1'b0;
      has_type_r <= ACC_CTRL;
      has_rw_r <= 1'b0;
      has_half_r <= 1'b0;
    end else begin
      if (has_fall) begin // RL13
        has_type_r <= access_type_select;
        has_rw_r <= read_write_select;
        has_half_r <= halfword_select;
      end
      if (has_fall) begin
        has_seen_r <= 1'b1;
      end else if (strobe_rise) begin
        has_seen_r <= 1'b0;
      end
    end
  end

  // selects in effect at the strobe fall, from the address strobe if it was used
  always_comb begin
    if (has_fall) begin
      sel_type = access_type_select;
      sel_rd = read_write_select;
      sel_half = halfword_select;
    end else if (has_seen_r) begin
      sel_type = has_type_r;
      sel_rd = has_rw_r;
      sel_half = has_half_r;
    end else begin
      sel_type = access_type_select;
      sel_rd = read_write_select;
      sel_half = halfword_select;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cur_type_r <= ACC_CTRL;
      cur_rd_r <= 1'b0;
      cur_half_r <= 1'b0;
    end else if (strobe_fall) begin // RL13
      cur_type_r <= sel_type;
      cur_rd_r <= sel_rd;
      cur_half_r <= sel_half;
    end
  end

  // first half of a data read must go fetch the word
  assign fetch_start = strobe_fall & sel_rd & ~sel_half & is_data(sel_type);

  always_ff @(posedge clk) begin
    if (srst) begin
      fetch_pend_r <= 1'b0;
      fetch_req <= 1'b0;
    end else begin
      fetch_req <= fetch_start; // RL4
      if (fetch_start) begin
        fetch_pend_r <= 1'b1;
      end else if (fetch_done) begin
        fetch_pend_r <= 1'b0;
      end
    end
  end

  // hold ready after the load so the bus settles before the host samples
  always_ff @(posedge clk) begin
    if (srst) begin
      settle_r <= 2'h0;
    end else if (fetch_pend_r && fetch_done) begin
      settle_r <= SETTLE_CNT; // RL12
    end else if (settle_r != 2'h0) begin
      settle_r <= settle_r - 2'h1;
    end
  end

  // data register: fetched word for reads, assembled halves for writes
  always_ff @(posedge clk) begin
    if (srst) begin
      data_r <= WORD_RST;
    end else if (fetch_pend_r && fetch_done) begin
      data_r <= fetch_data;
    end else if (strobe_rise && !cur_rd_r && is_data(cur_type_r)) begin
      if (cur_half_r) begin
        data_r[31:16] <= port_data_bus_in;
      end else begin
        data_r[15:0] <= port_data_bus_in;
      end
    end
  end

  // completion request after the second half; busy until the memory side answers
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_r <= 1'b0;
      op_req <= 1'b0;
      op_kind <= OP_WRITE;
      op_data <= WORD_RST;
    end else begin
      op_req <= 1'b0;
      if (strobe_rise && cur_half_r && ((!cur_rd_r && is_data(cur_type_r)) ||
          (cur_rd_r && cur_type_r == ACC_DATA_INC))) begin
        busy_r <= 1'b1; // RL5
        op_req <= 1'b1;
        op_kind <= cur_rd_r ? OP_READ_INC : OP_WRITE;
        op_data <= {port_data_bus_in, data_r[15:0]};
      end else if (op_done) begin
        busy_r <= 1'b0;
      end
    end
  end

  // control and address register writes pass straight through
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_wr <= 1'b0;
      reg_wr_sel <= ACC_CTRL;
      reg_wr_half <= 1'b0;
      reg_wr_data <= HW_RST;
    end else begin
      reg_wr <= strobe_rise & ~cur_rd_r & ~is_data(cur_type_r);
      if (strobe_rise) begin
        reg_wr_sel <= cur_type_r;
        reg_wr_half <= cur_half_r;
        reg_wr_data <= port_data_bus_in;
      end
    end
  end

  // read data bus; drives from the clock after the read strobe falls to the clock after it rises
  always_ff @(posedge clk) begin
    if (srst) begin
      dout_r <= HW_RST;
      oe_r <= 1'b0;
    end else begin
      if (strobe_rise || access_strobe_n) begin
        oe_r <= 1'b0;
      end else if (strobe_fall) begin
        oe_r <= sel_rd;
      end
      if (fetch_pend_r && fetch_done) begin
        dout_r <= half_of(fetch_data, cur_half_r);
      end else if (strobe_fall) begin
        unique case (sel_type)
          ACC_CTRL: dout_r <= half_of(ctrl_rd_data, sel_half);
          ACC_ADDR: dout_r <= half_of(addr_rd_data, sel_half);
          ACC_DATA_INC, ACC_DATA: dout_r <= half_of(data_r, sel_half);
        endcase
      end
    end
  end

  assign port_data_bus_out = dout_r;
  assign port_data_bus_oe = {HW_W{oe_r}};

  // ready: gated by chip select, high only for busy, fetch or settle
  assign port_ready_n = ~port_chip_select_n &
    (busy_r | fetch_pend_r | fetch_start | (settle_r != 2'h0)); // RL2 RL3 RL4 RL6 RL7

  a_strobe_form: assert property (@(posedge clk) disable iff (srst) // RL1
    (port_chip_select_n || data_strobe_a == data_strobe_b) |=> !fetch_req && !oe_r)
    else $error("access strobe active without a valid select");
  a_ready_gate: assert property (@(posedge clk) disable iff (srst) // RL2
    port_chip_select_n |-> !port_ready_n)
    else $error("ready high while chip select high");
  a_busy_hold: assert property (@(posedge clk) disable iff (srst) // RL3
    (busy_r && $fell(port_chip_select_n)) |-> port_ready_n)
    else $error("ready low at chip select fall while busy");
  a_fetch_issue: assert property (@(posedge clk) disable iff (srst) // RL4
    fetch_start |=> fetch_req && fetch_pend_r)
    else $error("fetch not issued on data read first half");
  a_fetch_wait: assert property (@(posedge clk) disable iff (srst) // RL4
    (fetch_pend_r && !port_chip_select_n) |-> port_ready_n)
    else $error("ready low before fetched data loaded");
  a_second_busy: assert property (@(posedge clk) disable iff (srst) // RL5
    (op_req && !port_chip_select_n) |-> busy_r && port_ready_n)
    else $error("ready low while completing transfer");
  a_plain_ready: assert property (@(posedge clk) disable iff (srst) // RL6
    (!access_strobe_n && !is_data(cur_type_r) && !busy_r && settle_r == 2'h0 &&
     !fetch_pend_r && !fetch_start) |-> !port_ready_n)
    else $error("ready high on a plain access");
  a_reg_noeffect: assert property (@(posedge clk) disable iff (srst) // RL7
    (reg_wr && !busy_r && !fetch_pend_r && settle_r == 2'h0 && !fetch_start) |->
    !port_ready_n)
    else $error("register write changed ready");
  a_read_settle: assert property (@(posedge clk) disable iff (srst) // RL12
    (fetch_pend_r && fetch_done && !port_chip_select_n && $stable(port_chip_select_n)) |=>
    port_ready_n [*2])
    else $error("ready fell before read data settled");
  a_sel_capture: assert property (@(posedge clk) disable iff (srst) // RL13
    (strobe_fall && !has_seen_r && !has_fall) |=> cur_type_r == $past(access_type_select))
    else $error("selects not captured at strobe fall");

endmodule
`default_nettype wire

/* File: tb/hpsr_host.sv */
// host model: one strobe access at a time, bus released between accesses
// assumes tb_top calls access by hierarchy on the device clock
`default_nettype none
module hpsr_host
  import hpsr_pkg::*;
(
  // clock
  input wire logic clk,
  // pins toward the device
  output logic cs_n,
  output logic ds_a,
  output logic ds_b,
  output logic [1:0] acc,
  output logic rw,
  output logic half,
  output logic [15:0] din,
  // pins from the device
  input wire logic [15:0] dout,
  input wire logic [15:0] oe,
  input wire logic rdy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: deselected, strobe high
  initial begin
    cs_n = 1'b1;
    ds_a = 1'b0;
    ds_b = 1'b0;
    acc = 2'h0;
    rw = 1'b0;
    half = 1'b0;
    din = 16'h0000;
  end
  // selects scrambled after the hold, so late capture in the device shows up
  task automatic access(input logic [1:0] t, input logic r, input logic h,
    input logic [15:0] d, output logic [15:0] q, output logic bsy, output logic lead_ok);
    int n;
    int lead;
    n = 0;
    lead = 0;
    bsy = 1'b0;
    @(posedge clk) #1;
    cs_n = 1'b0;
    acc = t;
    rw = r;
    half = h;
    din = d;
    @(posedge clk) #1;
    ds_a = 1'b1;
    @(posedge clk) #1;
    acc = ~t;
    rw = ~r;
    half = ~h;
    do begin
      @(negedge clk);
      n++;
      if (rdy_n === 1'b1) bsy = 1'b1;
      lead = (oe === 16'hffff && dout === q) ? lead + 1 : 0;
      q = dout;
    end while ((n < 4 || rdy_n !== 1'b0) && n < 200);
    if (rdy_n !== 1'b0) bsy = 1'bx; // limit ran out: unknown fails every compare
    @(posedge clk) #1;
    ds_a = 1'b0;
    // data must have stood two periods less 4 ns before ready fell
    lead_ok = lead * CLK_PERIOD_NS >= DATA_LEAD_NS;
    repeat (4) @(posedge clk);
    #1 cs_n = 1'b1;
    din = ~d; // held past the rising sample, then released lines change
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the host port handshake block
// assumes the host model in hpsr_host.sv; memory side answered here
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import hpsr_pkg::*;
  typedef struct {logic [1:0] t; logic r; logic h; logic [15:0] d; logic [15:0] q;
    logic b;} hpsr_row_t;
  hpsr_row_t rows [11];
  logic clk, srst, cs_n, ds_a, ds_b, rw, half, rdy_n, b, lead_ok;
  logic fetch_req, fetch_done, op_req, op_kind, op_done;
  logic as_n, reg_wr, reg_wr_half;
  logic [1:0] reg_wr_sel;
  logic [15:0] reg_wr_data;
  logic [18:0] reg_log;
  logic [1:0] acc, op_log;
  logic [15:0] din, dout, oe, q;
  logic [31:0] op_data, op_word;
  int miscompares, check_count, f_wait, o_wait, fetches;
  hpsr_port u_dut (.clk(clk), .srst(srst), .port_chip_select_n(cs_n), .data_strobe_a(ds_a),
    .data_strobe_b(ds_b), .addr_strobe_n(as_n),
    .access_type_select(acc), .read_write_select(rw), .halfword_select(half),
    .port_data_bus_in(din), .port_data_bus_out(dout), .port_data_bus_oe(oe),
    .port_ready_n(rdy_n), .fetch_req(fetch_req), .fetch_done(fetch_done),
    .fetch_data(32'hbeef_cafe), .op_req(op_req), .op_kind(op_kind), .op_data(op_data),
    .op_done(op_done), .reg_wr(reg_wr), .reg_wr_sel(reg_wr_sel),
    .reg_wr_half(reg_wr_half), .reg_wr_data(reg_wr_data),
    .ctrl_rd_data(32'h89ab_cdef), .addr_rd_data(32'h0246_8ace));
  hpsr_host u_host (.clk(clk), .cs_n(cs_n), .ds_a(ds_a), .ds_b(ds_b), .acc(acc), .rw(rw),
    .half(half), .din(din), .dout(dout), .oe(oe), .rdy_n(rdy_n));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // memory side: slow completion so the busy window spans the next select
  initial begin
    fetch_done = 1'b0;
    op_done = 1'b0;
    forever begin
      @(posedge clk) #1;
      fetch_done = (f_wait == 1);
      op_done = (o_wait == 1);
      if (f_wait > 0) f_wait--;
      if (o_wait > 0) o_wait--;
      if (srst) o_wait = 0;
      if (fetch_req === 1'b1) begin
        f_wait = 3;
        fetches++;
      end
      if (op_req === 1'b1) begin
        o_wait = 12;
        op_log = {op_log[0], op_kind};
        if (op_kind === 1'b0) op_word = op_data;
      end
      if (reg_wr === 1'b1) reg_log = {reg_wr_sel, reg_wr_half, reg_wr_data};
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog: tests need well under 2000 cycles
  initial begin
    #100000;
    miscompares++;
    results();
  end
  initial begin
    srst = 1'b1;
    as_n = 1'b1;
    rows = '{'{ACC_CTRL, 0, 0, 16'h1234, 0, 0}, '{ACC_CTRL, 1, 0, 0, 16'hcdef, 0},
      '{ACC_ADDR, 1, 1, 0, 16'h0246, 0}, '{ACC_DATA, 0, 0, 16'h1111, 0, 0},
      '{ACC_DATA, 0, 1, 16'h2222, 0, 0}, '{ACC_CTRL, 1, 1, 0, 16'h89ab, 1},
      '{ACC_DATA, 1, 0, 0, 16'hcafe, 1}, '{ACC_DATA, 1, 1, 0, 16'hbeef, 0},
      '{ACC_DATA_INC, 1, 0, 0, 16'hcafe, 1}, '{ACC_DATA_INC, 1, 1, 0, 16'hbeef, 0},
      '{ACC_ADDR, 1, 0, 0, 16'h8ace, 1}};
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    chk(rdy_n, 1'b0);
    foreach (rows[i]) begin
      u_host.access(rows[i].t, rows[i].r, rows[i].h, rows[i].d, q, b, lead_ok);
      if (rows[i].r) chk(q, rows[i].q);
      chk(b, rows[i].b);
      if (rows[i].r && rows[i].b && rows[i].t[0]) chk(lead_ok, 1'b1);
      @(negedge clk);
      chk(rdy_n, 1'b0);
      $display("row %0d done", i);
    end
    chk(op_word, 32'h2222_1111);
    chk(op_log, 2'b01);
    chk(fetches, 2);
    chk(reg_log, {ACC_CTRL, 1'b0, 16'h1234});
    // deselected or equal strobes never start an access
    @(posedge clk) #1;
    u_host.acc = ACC_DATA;
    u_host.rw = 1'b1;
    u_host.ds_a = 1'b1;
    repeat (4) @(posedge clk);
    #1 u_host.cs_n = 1'b0;
    u_host.ds_b = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(fetches, 2);
    chk(oe, 16'h0000);
    chk(rdy_n, 1'b0);
    u_host.cs_n = 1'b1;
    u_host.ds_a = 1'b0;
    u_host.ds_b = 1'b0;
    $display("strobe forming test done");
    // selects taken at the address strobe fall, pins scrambled before the access strobe
    @(posedge clk) #1;
    u_host.cs_n = 1'b0;
    u_host.acc = ACC_CTRL;
    u_host.rw = 1'b1;
    u_host.half = 1'b1;
    as_n = 1'b0;
    @(posedge clk) #1;
    as_n = 1'b1;
    u_host.acc = ACC_ADDR;
    u_host.rw = 1'b0;
    u_host.half = 1'b0;
    @(posedge clk) #1;
    u_host.ds_a = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(dout, 16'h89ab);
    chk(oe, 16'hffff);
    chk(rdy_n, 1'b0);
    u_host.ds_a = 1'b0;
    repeat (4) @(posedge clk);
    #1 u_host.cs_n = 1'b1;
    $display("address strobe test done");
    // reset in mid completion drops the busy state
    u_host.access(ACC_DATA, 1'b0, 1'b1, 16'h3333, q, b, lead_ok);
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    chk(rdy_n, 1'b0);
    u_host.access(ACC_CTRL, 1'b1, 1'b0, 16'h0, q, b, lead_ok);
    chk(q, 16'hcdef);
    chk(b, 1'b0);
    $display("mid reset test done");
    results();
  end
endmodule
`default_nettype wire
